// ===== logic/dcc_map.svh
// Register offsets, field positions and reset values of the dual comparator control block.
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH
`define DCC_ADDR_INTCTL 8'h0B
`define DCC_ADDR_PFLAGS 8'h0C
`define DCC_ADDR_PORT_A_DATA 8'h05
`define DCC_ADDR_CMPCTL 8'h1F
`define DCC_ADDR_PORT_A_DIRECTION 8'h85
`define DCC_ADDR_PENABLE 8'h8C
`define DCC_ADDR_VREFCTL 8'h9F
`define DCC_RST_INTCTL 8'h00
`define DCC_RST_PFLAGS 8'h00
`define DCC_RST_CMPCTL 8'h00
`define DCC_RST_PORT_A_DIRECTION 8'h1F
`define DCC_RST_PENABLE 8'h00
`define DCC_RST_VREFCTL 8'h00
`define DCC_RST_PORT_A_DATA 8'h00
`define DCC_BIT_FIRST_RES 6
`define DCC_BIT_SECOND_RES 7
`define DCC_BIT_INPUT_SW 3
`define DCC_BIT_CHANGE 6
`define DCC_BIT_PERIPHERAL_IRQ_ENABLE 6
`define DCC_BIT_GIE 7
`define DCC_MASK_CMPCTL_W 8'h0F
`define DCC_MASK_PFLAGS 8'h40
`define DCC_MASK_PENABLE 8'h40
`define DCC_MASK_PORT_A_DIRECTION 8'h1F
`define DCC_MASK_VREFCTL 8'hEF
`endif

// ===== logic/dcc_pkg.sv
// Types shared by the dual comparator control block.
package dcc_pkg;
  typedef enum logic [2:0] {
    DCC_MODE_RESET = 3'h0,
    DCC_MODE_ONE_IND = 3'h1,
    DCC_MODE_INT_REF = 3'h2,
    DCC_MODE_COMMON_REF = 3'h3,
    DCC_MODE_TWO_IND = 3'h4,
    DCC_MODE_ONE_ONLY = 3'h5,
    DCC_MODE_OUT_PINS = 3'h6,
    DCC_MODE_OFF = 3'h7
  } dcc_mode_t;
  typedef struct packed {
    logic [7:0] intctl;
    logic [7:0] pflags;
    logic [7:0] cmpctl;
    logic [7:0] port_a_direction;
    logic [7:0] penable;
    logic [7:0] vrefctl;
    logic [7:0] port_a_data;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] latch;
    logic [7:0] rdata;
  } dcc_state_t;
endpackage

// ===== logic/dcc_ctrl.sv
// Dual comparator control: registers, result sync, change detect and pin muxing.
//
// Summary of operation
// - Result bit high when plus exceeds minus.
// - Mode 010 routes internal reference to plus.
// - Results read in bits 7:6, write-proof.
// - Mode 110 puts raw results on pins 3,4.
// - Direction bits still gate those pin drivers.
// - Analog-configured port pins read as zero.
// - Result change sets change flag, except in a control access cycle.
// - Software writes 0 clears, 1 sets flag.
// - Interrupt needs flag and all three enables.
// - Flag sets even with enables clear.
// - Change during control read may be missed.
// - Mismatch persists until control register accessed.
// - Comparators run in sleep; interrupt wakes.
// - Mode 111 powers down both comparators.
// - Wake from sleep leaves control unchanged.
// - Reset loads mode 000, comparators powered on.
`include "dcc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dcc_ctrl
  import dcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] cmp_raw,
  input wire logic [4:0] port_a_pin_in,
  input wire logic sleep_active,
  output logic [4:0] port_a_pin_out,
  output logic [4:0] port_a_pin_oe,
  output logic [2:0] mode_field,
  output logic input_switch_bit,
  output logic int_ref_to_plus,
  output logic cmp_power_on,
  output logic [7:0] vref_control,
  output logic irq_req,
  output logic wake_req
);

  // ==========================================================
  // Helpers
  // ==========================================================

  // Pins that the comparator mode takes as analog inputs.
  function automatic logic [4:0] analog_pins(input logic [2:0] m);
    case (m)
      3'h0, 3'h2, 3'h3, 3'h4: analog_pins = 5'h0F;
      3'h1, 3'h6: analog_pins = 5'h07;
      3'h5: analog_pins = 5'h03;
      3'h7: analog_pins = 5'h00;
      default: analog_pins = 5'h0F;
    endcase
  endfunction

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    addr_is = (a == b);
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  dcc_state_t st_r;
  dcc_state_t st_nxt;
  logic cmp_access;
  logic mismatch;
  logic [1:0] live;
  logic [1:0] pin_sync1_r;
  logic [1:0] pin_sync2_r;

  assign live = st_r.sync2;
  assign mismatch = (live != st_r.latch);
  assign cmp_access = (reg_wr || reg_rd) && addr_is(reg_addr, `DCC_ADDR_CMPCTL);

  always_comb
  begin
    logic [4:0] an;
    logic [7:0] rd;
    an = analog_pins(st_r.cmpctl[2:0]);
    rd = 8'h00;
    st_nxt = st_r;
    st_nxt.sync1 = cmp_raw;
    st_nxt.sync2 = st_r.sync1;
    if (cmp_access)
    begin
      st_nxt.latch = live;
    end
    if (reg_wr)
    begin
      case (reg_addr)
        `DCC_ADDR_INTCTL: st_nxt.intctl = reg_wdata;
        `DCC_ADDR_PFLAGS: st_nxt.pflags = reg_wdata & `DCC_MASK_PFLAGS;
        `DCC_ADDR_CMPCTL: st_nxt.cmpctl = reg_wdata & `DCC_MASK_CMPCTL_W;
        `DCC_ADDR_PORT_A_DIRECTION: st_nxt.port_a_direction = reg_wdata & `DCC_MASK_PORT_A_DIRECTION;
        `DCC_ADDR_PENABLE: st_nxt.penable = reg_wdata & `DCC_MASK_PENABLE;
        `DCC_ADDR_VREFCTL: st_nxt.vrefctl = reg_wdata & `DCC_MASK_VREFCTL;
        `DCC_ADDR_PORT_A_DATA: st_nxt.port_a_data = reg_wdata & `DCC_MASK_PORT_A_DIRECTION;
        default: st_nxt.port_a_data = st_r.port_a_data;
      endcase
    end
    // mismatch keeps setting; set wins over clear
    // access may miss change
    // A change that lands in the cycle of a control access goes into the latch unflagged.
    // That is the permitted miss; software that reads the results sees the new value anyway.
    if (mismatch && !cmp_access)
    begin
      st_nxt.pflags[`DCC_BIT_CHANGE] = 1'b1;
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `DCC_ADDR_INTCTL: rd = st_r.intctl;
        `DCC_ADDR_PFLAGS: rd = st_r.pflags;
        `DCC_ADDR_CMPCTL: rd = {live, st_r.cmpctl[5:0]};
        `DCC_ADDR_PORT_A_DIRECTION: rd = st_r.port_a_direction;
        `DCC_ADDR_PENABLE: rd = st_r.penable;
        `DCC_ADDR_VREFCTL: rd = st_r.vrefctl;
        `DCC_ADDR_PORT_A_DATA: rd = {6'h00, pin_sync2_r & ~an[1:0]};
        default: rd = 8'h00;
      endcase
    end
    st_nxt.rdata = rd;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '{intctl: `DCC_RST_INTCTL, pflags: `DCC_RST_PFLAGS, cmpctl: `DCC_RST_CMPCTL,
                port_a_direction: `DCC_RST_PORT_A_DIRECTION, penable: `DCC_RST_PENABLE, vrefctl: `DCC_RST_VREFCTL,
                port_a_data: `DCC_RST_PORT_A_DATA, sync1: 2'h0, sync2: 2'h0, latch: 2'h0, rdata: 8'h00};
      pin_sync1_r <= 2'h0;
      pin_sync2_r <= 2'h0;
    end
    else
    begin
      st_r <= st_nxt;
      pin_sync1_r <= port_a_pin_in[1:0];
      pin_sync2_r <= pin_sync1_r;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign reg_rdata = st_r.rdata;
  assign mode_field = st_r.cmpctl[2:0];
  assign input_switch_bit = st_r.cmpctl[`DCC_BIT_INPUT_SW];
  assign vref_control = st_r.vrefctl;
  assign int_ref_to_plus = (st_r.cmpctl[2:0] == DCC_MODE_INT_REF);
  assign cmp_power_on = (st_r.cmpctl[2:0] != DCC_MODE_OFF);
  assign irq_req = st_r.pflags[`DCC_BIT_CHANGE] && st_r.penable[`DCC_BIT_CHANGE] &&
                   st_r.intctl[`DCC_BIT_PERIPHERAL_IRQ_ENABLE] && st_r.intctl[`DCC_BIT_GIE];
  assign wake_req = sleep_active && st_r.pflags[`DCC_BIT_CHANGE] && st_r.penable[`DCC_BIT_CHANGE];

  // raw results on pins 3 and 4; polarity is the analog core's
  // Pin data is a combinational mux so the raw result reaches the pin unsynchronised.
  always_comb
  begin
    port_a_pin_out = st_r.port_a_data[4:0];
    if (st_r.cmpctl[2:0] == DCC_MODE_OUT_PINS)
    begin
      port_a_pin_out[3] = cmp_raw[0];
      port_a_pin_out[4] = cmp_raw[1];
    end
  end
  assign port_a_pin_oe = ~st_r.port_a_direction[4:0];

  // ==========================================================
  // Checks
  // ==========================================================
  property p_flag_on_change;
    @(posedge core_clk) disable iff (!rst_b)
    (mismatch && !cmp_access) |=> st_r.pflags[`DCC_BIT_CHANGE];
  endproperty
  a_flag_on_change: assert property (p_flag_on_change) else $error("change flag not set");

  property p_irq_gate;
    @(posedge core_clk) disable iff (!rst_b)
    irq_req |-> (st_r.intctl[7:6] == 2'h3 && st_r.penable[6] && st_r.pflags[6]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without all enables");

  property p_result_ro;
    @(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `DCC_ADDR_CMPCTL) |=> (st_r.cmpctl[7:4] == 4'h0);
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("result bits written");

  sequence s_access;
    cmp_access;
  endsequence
  property p_mismatch_end;
    @(posedge core_clk) disable iff (!rst_b)
    s_access ##1 ($stable(live)) |-> !mismatch;
  endproperty
  a_mismatch_end: assert property (p_mismatch_end) else $error("mismatch persists after access");

  property p_sync_delay;
    @(posedge core_clk) disable iff (!rst_b)
    1'b1 |-> ##2 (live == $past(cmp_raw, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync depth wrong");

  property p_out_mux;
    @(posedge core_clk) disable iff (!rst_b)
    (mode_field == DCC_MODE_OUT_PINS) |-> (port_a_pin_out[4:3] == {cmp_raw[1], cmp_raw[0]});
  endproperty
  a_out_mux: assert property (p_out_mux) else $error("pin mux wrong");

  property p_oe;
    @(posedge core_clk) disable iff (!rst_b)
    st_r.port_a_direction[3] |-> !port_a_pin_oe[3];
  endproperty
  a_oe: assert property (p_oe) else $error("driver on while input");

  property p_off;
    @(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `DCC_ADDR_CMPCTL && reg_wdata[2:0] == 3'h7) |=> !cmp_power_on;
  endproperty
  a_off: assert property (p_off) else $error("mode 111 left comparators on");

  property p_analog_zero;
    @(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `DCC_ADDR_PORT_A_DATA && mode_field == 3'h0) |=> (reg_rdata == 8'h00);
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

  property p_analog_zero_m5;
    @(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `DCC_ADDR_PORT_A_DATA && mode_field == 3'h5) |=> (reg_rdata == 8'h00);
  endproperty
  a_analog_zero_m5: assert property (p_analog_zero_m5) else $error("mode 5 analog pin read nonzero");

  // ==========================================================
  // Checks: flags, interrupt and results
  // ==========================================================
  // clear by zero
  property p_flag_clear;
    @(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `DCC_ADDR_PFLAGS && !reg_wdata[`DCC_BIT_CHANGE] && !mismatch) |=>
      !st_r.pflags[`DCC_BIT_CHANGE];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("change flag not cleared");

  property p_flag_soft_set;
    @(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `DCC_ADDR_PFLAGS && reg_wdata[`DCC_BIT_CHANGE]) |=> st_r.pflags[`DCC_BIT_CHANGE];
  endproperty
  a_flag_soft_set: assert property (p_flag_soft_set) else $error("software set of flag lost");

  property p_flag_no_enable;
    @(posedge core_clk) disable iff (!rst_b)
    (mismatch && !cmp_access && !st_r.penable[`DCC_BIT_CHANGE]) |=> st_r.pflags[`DCC_BIT_CHANGE];
  endproperty
  a_flag_no_enable: assert property (p_flag_no_enable) else $error("flag needs enable");

  property p_irq_on;
    @(posedge core_clk) disable iff (!rst_b)
    (st_r.pflags[6] && st_r.penable[6] && st_r.intctl[6] && st_r.intctl[7]) |-> irq_req;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing with all enables");

  // Flags register keeps only its one bit.
  property p_flags_read_mask;
    @(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `DCC_ADDR_PFLAGS) |=> ((reg_rdata & ~`DCC_MASK_PFLAGS) == 8'h00);
  endproperty
  a_flags_read_mask: assert property (p_flags_read_mask) else $error("unused flag bit read high");

  property p_wake;
    @(posedge core_clk) disable iff (!rst_b)
    (sleep_active && st_r.pflags[6] && st_r.penable[6]) |-> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake request");

  // change walk
  // A result step seen in the sync chain must end in the flag two edges later.
  sequence s_result_moves;
    (st_r.sync1 != st_r.sync2) && (st_r.sync2 == st_r.latch || cmp_access);
  endsequence
  sequence s_quiet_bus;
    !cmp_access;
  endsequence
  property p_change_walk;
    @(posedge core_clk) disable iff (!rst_b)
    s_result_moves ##1 s_quiet_bus |=> st_r.pflags[`DCC_BIT_CHANGE];
  endproperty
  a_change_walk: assert property (p_change_walk) else $error("result change not flagged");

  property p_latch_load;
    @(posedge core_clk) disable iff (!rst_b)
    cmp_access |=> (st_r.latch == $past(live));
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch not loaded on access");

  property p_read_results;
    @(posedge core_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `DCC_ADDR_CMPCTL) |=> (reg_rdata[7:6] == $past(live) && reg_rdata[5:4] == 2'h0);
  endproperty
  a_read_results: assert property (p_read_results) else $error("result bits read wrong");

  // Read data stands one cycle only.
  property p_rdata_idle;
    @(posedge core_clk) disable iff (!rst_b)
    !reg_rd |=> (reg_rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data held past its cycle");

  // ==========================================================
  // Checks: modes and sleep
  // ==========================================================
  // reference select decode
  property p_ref_mode;
    @(posedge core_clk) disable iff (!rst_b)
    1'b1 |-> (int_ref_to_plus == (mode_field == 3'h2));
  endproperty
  a_ref_mode: assert property (p_ref_mode) else $error("reference select wrong");

  property p_normal_pins;
    @(posedge core_clk) disable iff (!rst_b)
    (mode_field != 3'h6) |-> (port_a_pin_out == st_r.port_a_data[4:0]);
  endproperty
  a_normal_pins: assert property (p_normal_pins) else $error("pin data not from port register");

  property p_power_on;
    @(posedge core_clk) disable iff (!rst_b)
    (mode_field != 3'h7) |-> cmp_power_on;
  endproperty
  a_power_on: assert property (p_power_on) else $error("comparators off in active mode");

  property p_sleep_keeps;
    @(posedge core_clk) disable iff (!rst_b)
    (sleep_active && !(reg_wr && reg_addr == `DCC_ADDR_CMPCTL)) |=> $stable(st_r.cmpctl);
  endproperty
  a_sleep_keeps: assert property (p_sleep_keeps) else $error("control changed in sleep");

endmodule
`default_nettype wire

// ===== tb/dcc_analog_model.sv
// Behavioural model of the two comparator cores and the five port pins.
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model
(
  input wire logic [7:0] vin_plus0,
  input wire logic [7:0] vin_plus1,
  input wire logic [7:0] vin_minus0,
  input wire logic [7:0] vin_minus1,
  input wire logic [7:0] vref_level,
  input wire logic int_ref_to_plus,
  input wire logic cmp_power_on,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  input wire logic [4:0] pin_ext,
  output logic [1:0] cmp_raw,
  output logic [4:0] pin_level
);
  logic [7:0] plus0;
  logic [7:0] plus1;
  assign plus0 = int_ref_to_plus ? vref_level : vin_plus0;
  assign plus1 = int_ref_to_plus ? vref_level : vin_plus1;
  assign cmp_raw = cmp_power_on ? {plus1 > vin_minus1, plus0 > vin_minus0} : 2'h0;
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & pin_ext);
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the dual comparator control block.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_map.svh"
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] a = 8'h00;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep = 1'b0;
  logic [7:0] vp0 = 8'h0A, vp1 = 8'h0A, vm0 = 8'h14, vm1 = 8'h3C, vref = 8'h00;
  logic [4:0] ext = 5'h03;
  logic [1:0] saved_res = 2'h0;
  logic [7:0] rdata, vrc;
  logic [4:0] pin_lvl, pin_out, pin_oe;
  logic [2:0] mode;
  logic [1:0] raw;
  logic isw, irf, pwr, irq, wake;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  dcc_ctrl dcc_ctrl_inst (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .cmp_raw(raw), .port_a_pin_in(pin_lvl), .sleep_active(sleep),
    .port_a_pin_out(pin_out), .port_a_pin_oe(pin_oe), .mode_field(mode), .input_switch_bit(isw),
    .int_ref_to_plus(irf), .cmp_power_on(pwr), .vref_control(vrc), .irq_req(irq), .wake_req(wake));
  dcc_analog_model dcc_analog_model_inst (.vin_plus0(vp0), .vin_plus1(vp1), .vin_minus0(vm0),
    .vin_minus1(vm1), .vref_level(vref), .int_ref_to_plus(irf), .cmp_power_on(pwr), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_ext(ext), .cmp_raw(raw), .pin_level(pin_lvl));
  // ==========================================
  // Clock, watchdog and bus tasks
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // The whole run needs well under a thousand cycles.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    a <= ad;
    wd <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge core_clk);
    rd <= 1'b1;
    a <= ad;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk(mode, 8'h00);
    rdc(`DCC_ADDR_PORT_A_DIRECTION, `DCC_RST_PORT_A_DIRECTION);
    rdc(`DCC_ADDR_PFLAGS, 8'h00);
    rdc(8'h40, 8'h00);
    wrr(`DCC_ADDR_CMPCTL, 8'hF3);
    rdc(`DCC_ADDR_CMPCTL, 8'h03);
  endtask
  task automatic t_change();
    @(posedge core_clk);
    vp0 <= 8'h1E;
    repeat (4) @(posedge core_clk);
    rdc(`DCC_ADDR_PFLAGS, 8'h40);
    chk(irq, 8'h00);
    wrr(`DCC_ADDR_PFLAGS, 8'h00);
    rdc(`DCC_ADDR_PFLAGS, 8'h40);
    rdc(`DCC_ADDR_CMPCTL, 8'h43);
    saved_res = rdata[7:6];
    wrr(`DCC_ADDR_PFLAGS, 8'h00);
    rdc(`DCC_ADDR_PFLAGS, 8'h00);
  endtask
  task automatic t_irq();
    wrr(`DCC_ADDR_PENABLE, 8'h40);
    wrr(`DCC_ADDR_INTCTL, 8'h40);
    wrr(`DCC_ADDR_PFLAGS, 8'h40);
    chk(irq, 8'h00);
    wrr(`DCC_ADDR_INTCTL, 8'hC0);
    chk(irq, 8'h01);
    wrr(`DCC_ADDR_PENABLE, 8'h00);
    chk(irq, 8'h00);
    wrr(`DCC_ADDR_PENABLE, 8'h40);
    @(posedge core_clk);
    sleep <= 1'b1;
    #1;
    chk(wake, 8'h01);
    rdc(`DCC_ADDR_CMPCTL, 8'h43);
    wrr(`DCC_ADDR_PFLAGS, 8'h00);
    chk(wake, 8'h00);
    @(posedge core_clk);
    sleep <= 1'b0;
  endtask
  task automatic t_pins();
    wrr(`DCC_ADDR_CMPCTL, 8'h06);
    wrr(`DCC_ADDR_PORT_A_DIRECTION, 8'h07);
    chk(pin_oe, 8'h18);
    chk(pin_out[4:3], 8'h01);
    wrr(`DCC_ADDR_PORT_A_DIRECTION, 8'h1F);
    chk(pin_oe, 8'h00);
  endtask
  task automatic t_ref();
    wrr(`DCC_ADDR_INTCTL, 8'h00);
    chk(irq, 8'h00);
    @(posedge core_clk);
    vref <= 8'h64;
    wrr(`DCC_ADDR_CMPCTL, 8'h02);
    chk(irf, 8'h01);
    repeat (4) @(posedge core_clk);
    rdc(`DCC_ADDR_CMPCTL, 8'hC2);
    chk(rdata[7:6] ^ saved_res, 8'h02);
    wrr(`DCC_ADDR_CMPCTL, 8'h07);
    chk(pwr, 8'h00);
    repeat (4) @(posedge core_clk);
    rdc(`DCC_ADDR_CMPCTL, 8'h07);
    rdc(`DCC_ADDR_PORT_A_DATA, 8'h03);
    wrr(`DCC_ADDR_CMPCTL, 8'h00);
    rdc(`DCC_ADDR_PORT_A_DATA, 8'h00);
  endtask
  task automatic t_fields();
    wrr(`DCC_ADDR_VREFCTL, 8'hFF);
    chk(vrc, `DCC_MASK_VREFCTL);
    rdc(`DCC_ADDR_VREFCTL, `DCC_MASK_VREFCTL);
    wrr(`DCC_ADDR_CMPCTL, 8'h0B);
    chk(isw, 8'h01);
    chk(mode, 8'h03);
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_change();
    t_irq();
    t_pins();
    t_ref();
    t_fields();
    close_out();
  end
endmodule
`default_nettype wire
